//--- core/pmcc_top.sv
/*
 Power-mode and clock controller top: mode sequencing, regulator and
 reference control, clock gating, prescaler, routing, voltage detector
 and register port. Assumes pins arrive asynchronous to ref_clk and the
 processor-side strobes are synchronous to it.
*/
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module pmcc_top (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Processor side, same clock
	input  wire logic       wait_for_interrupt_instr,
	input  wire logic       wait_for_event_instr,
	input  wire logic       irq_pending,
	input  wire logic       periph_event,
	// Option bytes
	input  wire logic [2:0] opt_bor_level,
	input  wire logic       opt_bor_disable,
	// Asynchronous pins
	input  wire logic [3:0] osc_ready,
	input  wire logic       hse_fail_pin,
	input  wire logic       supply_ok,
	input  wire logic       vref_ready,
	input  wire logic       ext_irq,
	input  wire logic       rtc_irq,
	input  wire logic       periph_halt_wake,
	input  wire logic       lp_wake_event,
	input  wire logic       pvd_above,
	// Mode and power outputs
	output logic            core_reset,
	output pmcc_pkg::pmcc_mode_t mode,
	output logic            low_power_regulator_mode,
	output logic            vref_on,
	output logic            brownout_reset_en,
	output logic      [2:0] bor_level,
	// Clock outputs
	output logic            cpu_clk_en,
	output logic      [7:0] periph_clk_en,
	output logic            mem_clk_en,
	output logic            rtc_clk_en,
	output logic      [3:0] osc_en,
	output logic      [1:0] system_clock_src,
	output logic            sys_tick,
	output logic      [1:0] rtc_src,
	output logic            clock_output_pin,
	output logic      [1:0] cco_src,
	// Detector and failure outputs
	output logic      [2:0] pvd_level,
	output logic            pvd_enable,
	output logic            pvd_irq,
	output logic            clock_failure_flag
);
	import pmcc_pkg::*;

	function automatic logic [3:0] one_hot(input logic [1:0] s);
		one_hot = 4'h1 << s;
	endfunction

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	localparam int NPIN = 12;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_reg;
	logic [NPIN-1:0] s2_reg;
	logic [NPIN-1:0] s3_reg;
	logic [NPIN-1:0] pin_f;
	assign pin_raw = {pvd_above, lp_wake_event, periph_halt_wake, rtc_irq,
		ext_irq, vref_ready, supply_ok, hse_fail_pin, osc_ready};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
					pin_f[gi]  <= 1'b0;
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi])
						pin_f[gi] <= s3_reg[gi];
				end
			end
		end
	endgenerate

	logic [3:0] osc_rdy_f;
	logic hse_fail_f, supply_f, vref_f, ext_f, rtc_f, hwake_f, lpev_f, above_f;
	assign osc_rdy_f  = pin_f[3:0];
	assign hse_fail_f = pin_f[4];
	assign supply_f   = pin_f[5];
	assign vref_f     = pin_f[6];
	assign ext_f      = pin_f[7];
	assign rtc_f      = pin_f[8];
	assign hwake_f    = pin_f[9];
	assign lpev_f     = pin_f[10];
	assign above_f    = pin_f[11];

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	logic [1:0] sel_reg;
	logic [2:0] presc_reg;
	logic [7:0] per_gate_reg;
	logic [1:0] core_gate_reg;
	logic [5:0] cfg_reg;
	logic [2:0] pvd_lvl_reg;
	logic [4:0] route_reg;
	logic       css_flag_reg;
	logic       pvd_flag_reg;
	logic       wr_cmd;
	logic [7:0] cmd;
	logic       css_evt;
	logic       pvd_evt;
	logic       opt_loaded_reg;

	assign wr_cmd = reg_wr && reg_addr == OFF_CMD;
	assign cmd    = wr_cmd ? reg_wdata : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sel_reg       <= SRC_HS_RC;
			presc_reg     <= PRESC_RESET;
			per_gate_reg  <= PER_GATE_RESET;
			core_gate_reg <= 2'h0;
			cfg_reg       <= 6'h00;
			pvd_lvl_reg   <= 3'h0;
			route_reg     <= 5'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFF_SYS_SEL:   sel_reg       <= reg_wdata[1:0];
				OFF_PRESC:     presc_reg     <= reg_wdata[2:0];
				OFF_PER_GATE:  per_gate_reg  <= reg_wdata;
				OFF_CORE_GATE: core_gate_reg <= reg_wdata[1:0];
				OFF_CFG:       cfg_reg       <= reg_wdata[5:0];
				OFF_PVD_LVL:   pvd_lvl_reg   <= (reg_wdata[2:0] > PVD_LVL_MAX) ?
					PVD_LVL_MAX : reg_wdata[2:0];
				OFF_ROUTE:     route_reg     <= reg_wdata[4:0];
				default: ;
			endcase
		end
	end

	// Sticky flags, set beats write-one clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			css_flag_reg <= 1'b0;
			pvd_flag_reg <= 1'b0;
		end else begin
			if (css_evt)
				css_flag_reg <= 1'b1;
			else if (reg_wr && reg_addr == OFF_STATUS && reg_wdata[ST_CSS_FAIL])
				css_flag_reg <= 1'b0;
			if (pvd_evt)
				pvd_flag_reg <= 1'b1;
			else if (reg_wr && reg_addr == OFF_STATUS && reg_wdata[ST_PVD_FLAG])
				pvd_flag_reg <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Clock switch unit
	// ---------------------------------------------
	pmcc_sw_if swif (.clk(ref_clk), .rst(rst));
	pmcc_mode_t mode_reg;
	assign swif.req_src  = sel_reg;
	assign swif.allow    = mode_reg == MD_RUN;
	assign swif.css_en   = cfg_reg[CFG_CSS_EN];
	assign swif.hse_fail = hse_fail_f;
	assign swif.osc_rdy  = osc_rdy_f;
	assign css_evt       = swif.css_evt;
	pmcc_clk_switch u_switch (.sw(swif));

	// ---------------------------------------------
	// Supply reset and option load
	// ---------------------------------------------
	logic core_reset_reg;
	logic [2:0] bor_level_reg;
	logic bor_en_reg;
	always_ff @(posedge ref_clk) begin
		if (rst || !supply_f) begin
			core_reset_reg <= 1'b1;
			opt_loaded_reg <= 1'b0;
			bor_level_reg  <= 3'h0;
			bor_en_reg     <= 1'b1;
		end else if (!opt_loaded_reg) begin
			opt_loaded_reg <= 1'b1;
			bor_level_reg  <= opt_bor_level;
			bor_en_reg     <= !opt_bor_disable;
		end else begin
			core_reset_reg <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Mode sequencer
	// ---------------------------------------------
	logic [11:0] wake_cnt_reg;
	logic        low_speed;
	assign low_speed = swif.cur_src == SRC_LS_XTAL || swif.cur_src == SRC_LS_RC;

	always_ff @(posedge ref_clk) begin
		if (rst || core_reset_reg) begin
			mode_reg     <= MD_RUN;
			wake_cnt_reg <= 12'h000;
		end else begin
			unique case (mode_reg)
				MD_RUN: begin
					if (cmd[CMD_HALT])
						mode_reg <= MD_HALT;
					else if (cmd[CMD_ACT_HALT])
						mode_reg <= MD_ACT_HALT;
					else if (cmd[CMD_LP_ENTER] && low_speed && !swif.busy)
						mode_reg <= MD_LP_RUN;
					else if (wait_for_interrupt_instr || wait_for_event_instr)
						mode_reg <= MD_WAIT;
				end
				MD_WAIT: begin
					if (irq_pending || periph_event || ext_f)
						mode_reg <= MD_RUN;
				end
				MD_LP_RUN: begin
					// Interrupts ignored here
					if (cmd[CMD_LP_EXIT])
						mode_reg <= MD_RUN;
					else if (wait_for_event_instr)
						mode_reg <= MD_LP_WAIT;
				end
				MD_LP_WAIT: begin
					if (lpev_f || periph_event)
						mode_reg <= MD_LP_RUN;
				end
				MD_ACT_HALT: begin
					if (rtc_f || ext_f) begin
						mode_reg     <= MD_WAKE;
						wake_cnt_reg <= 12'h000;
					end
				end
				MD_HALT: begin
					if (ext_f || hwake_f) begin
						mode_reg     <= MD_WAKE;
						wake_cnt_reg <= 12'h000;
					end
				end
				MD_WAKE: begin
					wake_cnt_reg <= wake_cnt_reg + 12'h001;
					if (cfg_reg[CFG_FAST_WAKE]) begin
						if (wake_cnt_reg >= FAST_WAKE_CYC - 12'h001)
							mode_reg <= MD_RUN;
					end else if (vref_f) begin
						mode_reg <= MD_RUN;
					end
				end
				default: mode_reg <= MD_RUN;
			endcase
		end
	end

	// ---------------------------------------------
	// Regulator, reference and clock gates
	// ---------------------------------------------
	logic       lp_reg_reg, vref_reg, bor_on_reg;
	logic       cpu_en_reg, mem_en_reg, rtc_en_reg;
	logic [7:0] per_en_reg;
	logic [3:0] osc_en_reg;
	logic       in_halt;
	assign in_halt = mode_reg == MD_HALT || mode_reg == MD_ACT_HALT;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lp_reg_reg <= 1'b0;
			vref_reg   <= 1'b1;
			bor_on_reg <= 1'b1;
		end else begin
			lp_reg_reg <= in_halt || mode_reg == MD_LP_RUN ||
				mode_reg == MD_LP_WAIT;
			vref_reg   <= !(mode_reg == MD_HALT && cfg_reg[CFG_REF_AUTO]);
			bor_on_reg <= bor_en_reg &&
				!(mode_reg == MD_HALT && cfg_reg[CFG_REF_AUTO]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cpu_en_reg <= 1'b1;
			per_en_reg <= PER_GATE_RESET;
			mem_en_reg <= 1'b1;
			rtc_en_reg <= 1'b1;
			osc_en_reg <= one_hot(SRC_HS_RC);
		end else begin
			cpu_en_reg <= (mode_reg == MD_RUN || mode_reg == MD_LP_RUN) &&
				!core_gate_reg[CORE_OFF_BIT];
			per_en_reg <= in_halt || mode_reg == MD_WAKE ? 8'h00 : per_gate_reg;
			mem_en_reg <= (mode_reg == MD_RUN || mode_reg == MD_WAIT) &&
				!core_gate_reg[MEM_OFF_BIT];
			rtc_en_reg <= mode_reg != MD_HALT;
			if (mode_reg == MD_HALT)
				osc_en_reg <= 4'h0;
			else if (mode_reg == MD_ACT_HALT)
				osc_en_reg <= one_hot(route_reg[1:0]);
			else
				osc_en_reg <= one_hot(swif.cur_src) | one_hot(sel_reg) |
					one_hot(route_reg[1:0]) | one_hot(route_reg[3:2]) |
					(cfg_reg[CFG_CSS_EN] ? one_hot(SRC_HS_RC) : 4'h0);
		end
	end

	// ---------------------------------------------
	// Prescaler and clock output
	// ---------------------------------------------
	logic [6:0] div_cnt_reg;
	logic [6:0] div_mask;
	logic       tick_reg, cco_reg;
	assign div_mask = 7'((8'h01 << presc_reg) - 8'h01);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_cnt_reg <= 7'h00;
			tick_reg    <= 1'b0;
			cco_reg     <= 1'b0;
		end else begin
			if ((div_cnt_reg & div_mask) == div_mask) begin
				div_cnt_reg <= 7'h00;
				tick_reg    <= 1'b1;
			end else begin
				div_cnt_reg <= div_cnt_reg + 7'h01;
				tick_reg    <= 1'b0;
			end
			if (!route_reg[ROUTE_CCO_EN])
				cco_reg <= 1'b0;
			else if (tick_reg)
				cco_reg <= !cco_reg;
		end
	end

	// ---------------------------------------------
	// Voltage detector
	// ---------------------------------------------
	logic above_prev_reg, pvd_irq_reg;
	assign pvd_evt = cfg_reg[CFG_PVD_EN] &&
		((above_prev_reg && !above_f && cfg_reg[CFG_PVD_FALL]) ||
		(!above_prev_reg && above_f && cfg_reg[CFG_PVD_RISE]));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			above_prev_reg <= 1'b0;
			pvd_irq_reg    <= 1'b0;
		end else begin
			above_prev_reg <= above_f;
			pvd_irq_reg    <= pvd_flag_reg && cfg_reg[CFG_PVD_EN];
		end
	end

	// ---------------------------------------------
	// Read port
	// ---------------------------------------------
	logic [7:0] rdata_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFF_CMD:       rdata_reg <= {5'h00, mode_reg};
				OFF_SYS_SEL:   rdata_reg <= {3'h0, swif.busy, swif.cur_src, sel_reg};
				OFF_PRESC:     rdata_reg <= {5'h00, presc_reg};
				OFF_PER_GATE:  rdata_reg <= per_gate_reg;
				OFF_CORE_GATE: rdata_reg <= {6'h00, core_gate_reg};
				OFF_CFG:       rdata_reg <= {2'h0, cfg_reg};
				OFF_PVD_LVL:   rdata_reg <= {5'h00, pvd_lvl_reg};
				OFF_ROUTE:     rdata_reg <= {3'h0, route_reg};
				OFF_STATUS:    rdata_reg <= {4'h0, opt_loaded_reg, above_f,
					pvd_flag_reg, css_flag_reg};
				default:       rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign reg_rdata                = rdata_reg;
	assign core_reset               = core_reset_reg;
	assign mode                     = mode_reg;
	assign low_power_regulator_mode = lp_reg_reg;
	assign vref_on                  = vref_reg;
	assign brownout_reset_en        = bor_on_reg;
	assign bor_level                = bor_level_reg;
	assign cpu_clk_en               = cpu_en_reg;
	assign periph_clk_en            = per_en_reg;
	assign mem_clk_en               = mem_en_reg;
	assign rtc_clk_en               = rtc_en_reg;
	assign osc_en                   = osc_en_reg;
	assign system_clock_src         = swif.cur_src;
	assign sys_tick                 = tick_reg;
	assign rtc_src                  = route_reg[1:0];
	assign clock_output_pin         = cco_reg;
	assign cco_src                  = route_reg[3:2];
	assign pvd_level                = pvd_lvl_reg;
	assign pvd_enable               = cfg_reg[CFG_PVD_EN];
	assign pvd_irq                  = pvd_irq_reg;
	assign clock_failure_flag       = css_flag_reg;
endmodule

//--- core/pmcc_pkg.sv
/*
 Package of the power-mode and clock controller: register offsets, field
 positions, reset values, source codes, mode states and timing counts.
 Assumes a 250 MHz ref_clk and an 8-bit register port with 4-bit address.
*/
package pmcc_pkg;
	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [3:0] OFF_CMD      = 4'h0;
	localparam logic [3:0] OFF_SYS_SEL  = 4'h1;
	localparam logic [3:0] OFF_PRESC    = 4'h2;
	localparam logic [3:0] OFF_PER_GATE = 4'h3;
	localparam logic [3:0] OFF_CORE_GATE = 4'h4;
	localparam logic [3:0] OFF_CFG      = 4'h5;
	localparam logic [3:0] OFF_PVD_LVL  = 4'h6;
	localparam logic [3:0] OFF_ROUTE    = 4'h7;
	localparam logic [3:0] OFF_STATUS   = 4'h8;
	// ---------------------------------------------
	// Field positions
	// ---------------------------------------------
	localparam int CMD_LP_ENTER  = 0;
	localparam int CMD_LP_EXIT   = 1;
	localparam int CMD_HALT      = 2;
	localparam int CMD_ACT_HALT  = 3;
	localparam int CORE_OFF_BIT  = 0;
	localparam int MEM_OFF_BIT   = 1;
	localparam int CFG_CSS_EN    = 0;
	localparam int CFG_FAST_WAKE = 1;
	localparam int CFG_REF_AUTO  = 2;
	localparam int CFG_PVD_EN    = 3;
	localparam int CFG_PVD_FALL  = 4;
	localparam int CFG_PVD_RISE  = 5;
	localparam int ROUTE_CCO_EN  = 4;
	localparam int ST_CSS_FAIL   = 0;
	localparam int ST_PVD_FLAG   = 1;
	// ---------------------------------------------
	// Sources and reset values
	// ---------------------------------------------
	localparam logic [1:0] SRC_HS_RC   = 2'h0;
	localparam logic [1:0] SRC_HS_XTAL = 2'h1;
	localparam logic [1:0] SRC_LS_XTAL = 2'h2;
	localparam logic [1:0] SRC_LS_RC   = 2'h3;
	localparam logic [2:0] PRESC_RESET = 3'h3;
	localparam logic [7:0] PER_GATE_RESET = 8'hFF;
	localparam logic [2:0] PVD_LVL_MAX = 3'h6;
	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int FAST_WAKE_NS = 5000;
	localparam logic [11:0] FAST_WAKE_CYC = 12'(FAST_WAKE_NS * CLK_MHZ / 1000);
	// ---------------------------------------------
	// Power modes
	// ---------------------------------------------
	typedef enum logic [2:0] {
		MD_RUN, MD_WAIT, MD_LP_RUN, MD_LP_WAIT, MD_ACT_HALT, MD_HALT, MD_WAKE
	} pmcc_mode_t;
endpackage

//--- core/pmcc_sw_if.sv
/*
 Interface between the mode controller and the clock switch unit.
 Assumes both ends run on ref_clk with the same synchronous reset.
*/
`timescale 1ns/1ps
interface pmcc_sw_if (
	input wire logic clk,
	input wire logic rst
);
	logic [1:0] req_src;
	logic       allow;
	logic       css_en;
	logic       hse_fail;
	logic [3:0] osc_rdy;
	logic [1:0] cur_src;
	logic       busy;
	logic       css_evt;
	modport ctrl (input clk, rst, cur_src, busy, css_evt,
		output req_src, allow, css_en, hse_fail, osc_rdy);
	modport sw (input clk, rst, req_src, allow, css_en, hse_fail, osc_rdy,
		output cur_src, busy, css_evt);
endinterface

//--- core/pmcc_clk_switch.sv
/*
 Clock switch unit: safe changeover of the system clock source and the
 clock security fallback. Assumes synchronised oscillator status inputs.
*/
`timescale 1ns/1ps
module pmcc_clk_switch (
	pmcc_sw_if.sw sw
);
	import pmcc_pkg::*;
	typedef enum logic {SW_IDLE, SW_WAIT} pmcc_sw_state_t;
	pmcc_sw_state_t state_reg;
	logic [1:0]     cur_reg;
	logic           busy_reg;
	logic           evt_reg;

	assign sw.cur_src = cur_reg;
	assign sw.busy    = busy_reg;
	assign sw.css_evt = evt_reg;

	always_ff @(posedge sw.clk) begin
		if (sw.rst) begin
			cur_reg   <= SRC_HS_RC;
			busy_reg  <= 1'b0;
			evt_reg   <= 1'b0;
			state_reg <= SW_IDLE;
		end else if (sw.css_en && cur_reg == SRC_HS_XTAL && sw.hse_fail) begin
			cur_reg   <= SRC_HS_RC;
			evt_reg   <= 1'b1;
			busy_reg  <= 1'b0;
			state_reg <= SW_IDLE;
		end else begin
			evt_reg <= 1'b0;
			unique case (state_reg)
				SW_IDLE: begin
					if (sw.allow && sw.req_src != cur_reg) begin
						state_reg <= SW_WAIT;
						busy_reg  <= 1'b1;
					end
				end
				SW_WAIT: begin
					if (sw.req_src == cur_reg) begin
						state_reg <= SW_IDLE;
						busy_reg  <= 1'b0;
					end else if (sw.osc_rdy[sw.req_src]) begin
						cur_reg   <= sw.req_src;
						state_reg <= SW_IDLE;
						busy_reg  <= 1'b0;
					end
				end
			endcase
		end
	end
endmodule

//--- tb/pmcc_assertions.sv
/*
 Port checker of pmcc_top, bound from the bench.
 Assumes one ref_clk domain and rst synchronous high.
*/
`timescale 1ns/1ps
module pmcc_assertions
	import pmcc_pkg::*;
(
	// Clock, reset, register port
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic           [3:0] reg_addr,
	input wire logic           [7:0] reg_wdata,
	input wire logic                 reg_wr,
	// Mode and clock signals
	input wire logic                 irq_pending,
	input wire logic                 wait_for_event_instr,
	input wire pmcc_pkg::pmcc_mode_t mode,
	input wire logic                 low_power_regulator_mode,
	input wire logic                 cpu_clk_en,
	input wire logic                 rtc_clk_en,
	input wire logic           [1:0] system_clock_src,
	input wire logic                 clock_failure_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_wait_cpu_off: assert property (mode == MD_WAIT && $past(mode) == MD_WAIT |-> !cpu_clk_en)
		else $error("cpu clock runs in wait");
	a_lp_irq_kept: assert property (mode == MD_LP_RUN && irq_pending && !reg_wr && !wait_for_event_instr
		|=> mode == MD_LP_RUN) else $error("interrupt left low-power run");
	a_wfe_lp_wait: assert property (mode == MD_LP_RUN && wait_for_event_instr && !reg_wr
		|=> mode == MD_LP_WAIT) else $error("no low-power wait");
	a_run_main_reg: assert property (mode == MD_RUN && $past(mode) == MD_RUN
		|-> !low_power_regulator_mode) else $error("low-power regulator in run");
	a_halt_low_reg: assert property (mode inside {MD_HALT, MD_ACT_HALT} && $past(mode) == mode
		|-> low_power_regulator_mode) else $error("main regulator in halt");
	a_ahalt_rtc_on: assert property (mode == MD_ACT_HALT && $past(mode) == MD_ACT_HALT
		|-> rtc_clk_en && !cpu_clk_en) else $error("active-halt clocks wrong");
	a_css_flag_set: assert property ($rose(clock_failure_flag)
		|-> $past(system_clock_src, 2) == SRC_HS_XTAL) else $error("failure flag without switchover");
	a_fail_sticky: assert property (clock_failure_flag && !(reg_wr && reg_addr == OFF_STATUS)
		|=> clock_failure_flag) else $error("failure flag lost");
endmodule

//--- tb/pmcc_osc_model.sv
/*
 Oscillators and reference voltage facing pmcc_top.
 Assumes enables from the controller on the shared ref_clk.
*/
`timescale 1ns/1ps
module pmcc_osc_model #(
	parameter int START_CYC = 30,
	parameter int VREF_CYC  = 3000
) (
	input  wire logic       ref_clk,
	input  wire logic [3:0] osc_en,
	input  wire logic       hse_dead,
	input  wire logic       vref_on,
	output logic      [3:0] osc_ready = 4'h0,
	output logic            vref_ready = 1'h0
);
	int run_cnt [4];
	int ref_cnt = 0;
	// Ready after startup; a dead crystal never reports ready
	always @(posedge ref_clk) begin
		for (int i = 0; i < 4; i++) begin
			run_cnt[i] = osc_en[i] ? run_cnt[i] + 1 : 0;
			osc_ready[i] <= run_cnt[i] > START_CYC && !(i == 1 && hse_dead);
		end
		ref_cnt = vref_on ? ref_cnt + 1 : 0;
		vref_ready <= ref_cnt > VREF_CYC;
	end
endmodule

//--- tb/testbench.sv
/*
 Self-checking bench of pmcc_top through its register port.
 Assumes the oscillator model and the bound port checker.
*/
`timescale 1ns/1ps
module testbench;
	import pmcc_pkg::*;
	logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, ext_irq = 1'h0, rtc_irq = 1'h0;
	logic wait_for_interrupt_instr = 1'h0, wait_for_event_instr = 1'h0, irq_pending = 1'h0;
	logic periph_event = 1'h0, opt_bor_disable = 1'h0, hse_fail_pin = 1'h0, supply_ok = 1'h1;
	logic periph_halt_wake = 1'h0, lp_wake_event = 1'h0, pvd_above = 1'h0;
	logic core_reset, low_power_regulator_mode, vref_on, brownout_reset_en, cpu_clk_en, mem_clk_en;
	logic rtc_clk_en, sys_tick, clock_output_pin, pvd_enable, pvd_irq, clock_failure_flag, vref_ready;
	logic [3:0] reg_addr = 4'h0, osc_ready, osc_en;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, periph_clk_en, d, n;
	logic [2:0] opt_bor_level = 3'h2, bor_level, pvd_level;
	logic [1:0] system_clock_src, rtc_src, cco_src;
	logic [1:0] srcs [4] = '{SRC_HS_XTAL, SRC_LS_XTAL, SRC_LS_RC, SRC_HS_RC};
	pmcc_mode_t mode;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	pmcc_top pmcc_top_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.wait_for_interrupt_instr, .wait_for_event_instr, .irq_pending, .periph_event, .opt_bor_level,
		.opt_bor_disable, .osc_ready, .hse_fail_pin, .supply_ok, .vref_ready, .ext_irq, .rtc_irq,
		.periph_halt_wake, .lp_wake_event, .pvd_above, .core_reset, .mode, .low_power_regulator_mode,
		.vref_on, .brownout_reset_en, .bor_level, .cpu_clk_en, .periph_clk_en, .mem_clk_en, .rtc_clk_en,
		.osc_en, .system_clock_src, .sys_tick, .rtc_src, .clock_output_pin, .cco_src, .pvd_level,
		.pvd_enable, .pvd_irq, .clock_failure_flag);
	pmcc_osc_model pmcc_osc_model_inst (.ref_clk, .osc_en, .hse_dead(hse_fail_pin), .vref_on, .osc_ready,
		.vref_ready);
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %0t got %h want %h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'h1, a, v};
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		{reg_rd, reg_addr} <= {1'h1, a};
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic wm(input logic [2:0] m);
		for (int i = 0; i < 5000 && mode !== m; i++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		chk(mode, m);
	endtask
	task automatic ws(input logic [1:0] s);
		for (int i = 0; i < 500 && system_clock_src !== s; i++) @(posedge ref_clk);
		chk(system_clock_src, s);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'h0;
		for (int i = 0; i < 100 && core_reset !== 1'h0; i++) @(posedge ref_clk);
		chk({core_reset, bor_level}, 8'h02);
		chk(system_clock_src, SRC_HS_RC);
		rd(OFF_PRESC);
		chk(d, 8'h03);
		rd(4'h9);
		chk(d, 8'h00);
		wr(OFF_PRESC, 8'h02);
		n = 8'h00;
		repeat (16) @(negedge ref_clk) n += sys_tick;
		chk(n, 8'h04);
		foreach (srcs[i]) begin
			wr(OFF_SYS_SEL, {6'h00, srcs[i]});
			chk(system_clock_src, srcs[(i + 3) % 4]);
			ws(srcs[i]);
		end
		wr(OFF_ROUTE, 8'h19);
		@(negedge ref_clk);
		chk({rtc_src, cco_src}, 8'h06);
		n = 8'h00;
		repeat (8) @(negedge ref_clk);
		repeat (16) @(negedge ref_clk) n += clock_output_pin;
		chk(n, 8'h08);
		chk(osc_en, 8'h07);
		wr(OFF_SYS_SEL, 8'h01);
		ws(SRC_HS_XTAL);
		wr(OFF_CFG, 8'h01);
		hse_fail_pin <= 1'h1;
		ws(SRC_HS_RC);
		wr(OFF_SYS_SEL, 8'h00);
		rd(OFF_STATUS);
		chk(d[0], 8'h01);
		@(posedge ref_clk) hse_fail_pin <= 1'h0;
		wr(OFF_STATUS, 8'h01);
		rd(OFF_STATUS);
		chk(d[0], 8'h00);
		wr(OFF_CORE_GATE, 8'h03);
		wr(OFF_PER_GATE, 8'h5A);
		repeat (2) @(negedge ref_clk);
		chk({cpu_clk_en, mem_clk_en, periph_clk_en[5:0]}, 8'h1A);
		wr(OFF_CORE_GATE, 8'h00);
		wr(OFF_PVD_LVL, 8'h07);
		wr(OFF_CFG, 8'h18);
		rd(OFF_PVD_LVL);
		chk({pvd_enable, pvd_level, d[3:0]}, 8'hE6);
		@(posedge ref_clk) pvd_above <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk(pvd_irq, 8'h00);
		pvd_above <= 1'h0;
		repeat (8) @(posedge ref_clk);
		chk(pvd_irq, 8'h01);
		@(posedge ref_clk) wait_for_interrupt_instr <= 1'h1;
		@(posedge ref_clk) wait_for_interrupt_instr <= 1'h0;
		wm(MD_WAIT);
		chk(cpu_clk_en, 8'h00);
		irq_pending <= 1'h1;
		wm(MD_RUN);
		irq_pending <= 1'h0;
		wr(OFF_SYS_SEL, 8'h03);
		ws(SRC_LS_RC);
		wr(OFF_CMD, 8'h01);
		wm(MD_LP_RUN);
		chk({mem_clk_en, low_power_regulator_mode, system_clock_src}, 8'h07);
		{irq_pending, ext_irq} <= 2'h3;
		repeat (10) @(posedge ref_clk);
		chk(mode, MD_LP_RUN);
		{irq_pending, ext_irq} <= 2'h0;
		@(posedge ref_clk) wait_for_event_instr <= 1'h1;
		@(posedge ref_clk) wait_for_event_instr <= 1'h0;
		wm(MD_LP_WAIT);
		chk(cpu_clk_en, 8'h00);
		lp_wake_event <= 1'h1;
		wm(MD_LP_RUN);
		lp_wake_event <= 1'h0;
		wr(OFF_CMD, 8'h02);
		wm(MD_RUN);
		chk(low_power_regulator_mode, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(OFF_CMD, i ? 8'h08 : 8'h04);
			wm(i ? MD_ACT_HALT : MD_HALT);
			chk({periph_clk_en[4:0], low_power_regulator_mode, cpu_clk_en, rtc_clk_en}, i ? 8'h05 : 8'h04);
			{rtc_irq, ext_irq} <= i ? 2'h2 : 2'h1;
			wm(MD_RUN);
			{rtc_irq, ext_irq} <= 2'h0;
			repeat (8) @(posedge ref_clk);
		end
		wr(OFF_CFG, 8'h06);
		wr(OFF_CMD, 8'h04);
		wm(MD_HALT);
		chk({vref_on, brownout_reset_en}, 8'h00);
		ext_irq <= 1'h1;
		wm(MD_RUN);
		chk(vref_ready, 8'h00);
		print_verdict();
	end
endmodule
bind pmcc_top pmcc_assertions pmcc_assertions_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.irq_pending, .wait_for_event_instr, .mode, .low_power_regulator_mode, .cpu_clk_en, .rtc_clk_en,
	.system_clock_src, .clock_failure_flag);
